// ---- bench/fpcd_flash_model.sv ----
/*
  Behavioural x16 flash on the controller pins: command decode, secret
  word, settings word, global lock. Assumes one device, pins of fpcd_top.
*/
`timescale 1ns/1ns
`default_nettype none
module fpcd_flash_model (
  // flash pins
  input wire logic [21:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_dq_oe,
  output logic [15:0] fl_dq_in,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n
);
  logic [15:0] pw [4];
  logic [15:0] program_settings = 16'hFFFF;
  logic [15:0] rd_val;
  logic [15:0] last = 16'h0000;
  // power-up always starts in normal mode
  logic [7:0] mode = 8'h00;
  logic glb = 1'b0;
  logic irr = 1'b0;
  logic [18:0] h1 = '0;
  logic [18:0] h2 = '0;
  logic [18:0] cur;
  // only a10..a0 and dq7..dq0 take part in decode
  assign cur = {fl_addr[10:0], fl_dq_out[7:0]};
  always @(posedge fl_we_n)
  begin
    if (!fl_ce_n && fl_dq_oe)
    begin
      h2 <= h1;
      h1 <= cur;
      // a consumed data cycle must not start a new pattern
      if (h1[7:0] == 8'hA0 && mode == 8'h60)
      begin
        pw[fl_addr[1:0]] <= fl_dq_out;
        h1 <= '0;
      end
      else if (h1[7:0] == 8'hA0 && (mode == 8'h40 || mode == 8'h50))
      begin
        if (mode == 8'h40)
          program_settings <= fl_dq_out;
        else
          glb <= 1'b1;
        h1 <= '0;
      end
      else if (cur[7:0] == 8'hF0 || (h1[7:0] == 8'h90 && cur[7:0] == 8'h00))
        mode <= 8'h00;
      else if (h2 == 19'h555AA && h1 == 19'h2AA55 && cur[18:8] == 11'h555)
      begin
        if (cur[7:0] == 8'h87)
          irr <= 1'b1;
        else
          mode <= cur[7:0];
      end
      else if (cur == 19'h05598)
        mode <= 8'h98;
    end
  end
  always_comb
    rd_val = mode == 8'h60 ? pw[fl_addr[1:0]] : mode == 8'h50 ? {15'h7FFF, ~glb} :
      mode == 8'h40 ? program_settings : ~fl_addr[15:0];
  always @(posedge fl_oe_n)
    last <= rd_val;
  // released bus shows the inverse of the last word
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd_val : ~last;
endmodule // fpcd_flash_model
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for fpcd_top: APB master tasks, read results checked
  from a queue by a monitor. Assumes the flash model on the pins.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fpcd_defs.svh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic watch = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_out;
  logic [15:0] fl_dq_in;
  logic fl_dq_oe;
  logic fl_ce_n;
  logic fl_we_n;
  logic fl_oe_n;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [32:0] expq [$];
  logic [31:0] seed = 32'h0000_9583;
  logic [15:0] pwv [4];
  logic [21:0] a;
  logic [4:0] ops [7] = '{`FPCD_OP_EXIT3, `FPCD_OP_CFI1, `FPCD_OP_CFI3, `FPCD_OP_EXIT1,
    `FPCD_OP_MEXIT, `FPCD_OP_RAW, `FPCD_OP_READ};
  always #4 pclk = ~pclk;
  fpcd_top #(.STROBE_CYC(1)) fpcd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n));
  fpcd_flash_model fpcd_flash_model_inst (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d,
    input logic chk, input logic [32:0] exp, output logic [31:0] q);
    if (chk)
      expq.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    watch <= chk;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    watch <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, ad, d, 1'b0, 33'h0, q);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [32:0] exp);
    logic [31:0] q;
    xfer(1'b0, ad, 32'h0, 1'b1, exp, q);
  endtask
  task automatic setw(input logic [21:0] ad, input logic [31:0] d);
    wr(`FPCD_REG_ADDR, {10'h000, ad});
    wr(`FPCD_REG_WDATA, d);
  endtask
  // busy polls are not checked, only bounded
  task automatic run(input logic [4:0] op);
    logic [31:0] q;
    int n;
    n = 0;
    wr(`FPCD_REG_CTRL, {27'h0, op});
    do
    begin
      xfer(1'b0, `FPCD_REG_STATUS, 32'h0, 1'b0, 33'h0, q);
      n++;
    end
    while (q[0] !== 1'b0 && n < 200);
    if (n >= 200)
      err_count++;
  endtask
  task automatic sts(input logic [4:0] l, input logic o, input logic g, input logic r);
    rd(`FPCD_REG_STATUS, {19'h0, l, 4'h0, o, g, r, ~r, 1'b0});
  endtask
  task automatic rdat(input logic [15:0] d);
    rd(`FPCD_REG_RDATA, {17'h0, d});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && watch)
      check($sformatf("read %h", paddr), {pslverr, prdata}, expq.pop_front());
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`FPCD_REG_STATUS, 33'h0_0000_0000);
    rd(12'h01C, 33'h1_0000_0000);
    setw(22'h0, 32'h0000_0060);
    run(`FPCD_OP_ENTRY3);
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      pwv[k] = seed[15:0];
      setw(22'(k), {16'h0000, pwv[k]});
      run(`FPCD_OP_PW_PROG);
    end
    for (int k = 3; k >= 0; k--)
    begin
      setw(22'(k), 32'h0);
      run(`FPCD_OP_PW_READ);
      rdat(pwv[k]);
    end
    wr(`FPCD_REG_SECLO, {pwv[1], pwv[0]});
    wr(`FPCD_REG_SECHI, {pwv[3], pwv[2]});
    run(`FPCD_OP_PW_SUBMIT);
    sts(5'h00, 1'b0, 1'b0, 1'b0);
    run(`FPCD_OP_IRR_LOCK);
    sts(5'h00, 1'b0, 1'b0, 1'b1);
    setw(22'h0, 32'h0000_0050);
    run(`FPCD_OP_ENTRY3);
    run(`FPCD_OP_GLB_READ);
    rdat(16'hFFFF);
    run(`FPCD_OP_IRR_LOCK);
    sts(5'h00, 1'b0, 1'b1, 1'b0);
    run(`FPCD_OP_EXIT1);
    setw(22'h0, 32'h0000_0040);
    run(`FPCD_OP_ENTRY3);
    setw(22'h0, 32'h0);
    run(`FPCD_OP_PSR_PROG);
    run(`FPCD_OP_READ);
    rdat(16'hFFE8);
    seed = xs(seed);
    a = seed[21:0];
    setw(a, 32'h0);
    foreach (ops[i])
    begin
      run(ops[i]);
      sts(5'h00, 1'b0, 1'b1, 1'b0);
    end
    rdat(~a[15:0]);
    wr(`FPCD_REG_CTRL, 32'h0000_0011);
    sts(5'h00, 1'b0, 1'b1, 1'b1);
    setw(22'h012340, 32'h000F_0000);
    run(`FPCD_OP_BUF_START);
    sts(5'h10, 1'b1, 1'b1, 1'b0);
    run(`FPCD_OP_BUF_CONF);
    sts(5'h10, 1'b1, 1'b1, 1'b1);
    setw(22'h012350, 32'h0);
    run(`FPCD_OP_BUF_WORD);
    sts(5'h10, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      setw(22'h012340 + 22'(i), seed);
      run(`FPCD_OP_BUF_WORD);
    end
    sts(5'h00, 1'b1, 1'b1, 1'b0);
    run(`FPCD_OP_BUF_WORD);
    sts(5'h00, 1'b1, 1'b1, 1'b1);
    run(`FPCD_OP_BUF_CONF);
    sts(5'h00, 1'b0, 1'b1, 1'b0);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire

// ---- verilog/fpcd_cyc_if.sv ----
/*
  Request and answer between the sequencer and the bus cycle engine.
  Assumes both ends share pclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface fpcd_cyc_if;
  logic req;
  logic rd;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output rd, output addr, output wdata, input done, input rdata);
  modport eng (input req, input rd, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ---- verilog/fpcd_cycle.sv ----
/*
  One asynchronous flash bus cycle per request: setup, strobe, hold.
  Assumes flash data input is synchronous to pclk and a single device.
*/
`timescale 1ns/1ns
`default_nettype none
module fpcd_cycle
  import fpcd_pkg::*;
#(
  parameter int STROBE_CYC = (`FPCD_STROBE_NS + `FPCD_CLK_NS - 1) / `FPCD_CLK_NS
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  fpcd_cyc_if.eng cyc,
  // flash pins
  output logic [21:0] fl_addr,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  initial begin
    if (STROBE_CYC < 1 || STROBE_CYC > 255)
      $error("strobe count out of range");
  end

  fpcd_eng_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic [21:0] a_reg, a_next;
  logic [15:0] d_reg, d_next, rdat_reg, rdat_next;
  logic done_reg, done_next;

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    a_next = a_reg;
    d_next = d_reg;
    rdat_next = rdat_reg;
    done_next = 1'b0;
    case (st_reg)
      EN_IDLE:
      begin
        if (cyc.req)
        begin
          rd_next = cyc.rd;
          a_next = cyc.addr;
          d_next = cyc.wdata;
          st_next = EN_SETUP;
        end
      end
      EN_SETUP:
      begin
        cnt_next = 8'(STROBE_CYC - 1);
        st_next = EN_STROBE;
      end
      EN_STROBE:
      begin
        if (cnt_reg == 8'h00)
        begin
          // sample at the end of the strobe, data is settled by then
          if (rd_reg)
            rdat_next = fl_dq_in;
          st_next = EN_HOLD;
        end
        else
          cnt_next = cnt_reg - 8'h01;
      end
      EN_HOLD:
      begin
        done_next = 1'b1;
        st_next = EN_IDLE;
      end
      default: st_next = EN_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= EN_IDLE;
      cnt_reg <= 8'h00;
      rd_reg <= 1'b0;
      a_reg <= 22'h000000;
      d_reg <= 16'h0000;
      rdat_reg <= 16'h0000;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      a_reg <= a_next;
      d_reg <= d_next;
      rdat_reg <= rdat_next;
      done_reg <= done_next;
    end
  end

  // pins registered from the next state so they change with the phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_addr <= 22'h000000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end
    else
    begin
      fl_addr <= a_next;
      fl_dq_out <= d_next;
      fl_dq_oe <= (st_next != EN_IDLE) && !rd_next;
      fl_ce_n <= (st_next == EN_IDLE);
      fl_we_n <= !((st_next == EN_STROBE) && !rd_next);
      fl_oe_n <= !((st_next == EN_STROBE) && rd_next);
    end
  end

  assign cyc.done = done_reg;
  assign cyc.rdata = rdat_reg;

  chk_no_contention: assert property (@(posedge pclk) disable iff (!presetn)
    !(fl_dq_oe && !fl_oe_n)) else $error("host drives data during a read");
  chk_strobe_done: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fl_ce_n) |-> $past(done_next)) else $error("cycle ended without answer");
endmodule // fpcd_cycle
`default_nettype wire

// ---- verilog/fpcd_defs.svh ----
/*
  Constants for the flash protection command controller: command cycle
  addresses and data, operation codes, register offsets and timing.
  Assumes inclusion by the controller package and the bench only.
*/
//
// Summary of operation
// - Secret word programming: A0H cycle, then portion address and value cycle.
// - Submit: 25H, 03H, four portions at 00H-03H, 29H; checked at end.
// - Host drives reserved settings bits 15 to 5 and 3 high when programming.
// - Irreversible block lock only issued while global lock bit reads one.
// - Buffer word count is words minus one, at most 15.
// - Buffered words share address bits 21 to 4 with the first word.
`ifndef FPCD_DEFS_SVH
`define FPCD_DEFS_SVH

// command cycle addresses and data
`define FPCD_ADDR_U1 22'h000555
`define FPCD_ADDR_U2 22'h0002AA
`define FPCD_ADDR_CFI 22'h000055
`define FPCD_ADDR_ZERO 22'h000000
`define FPCD_DATA_U1 16'h00AA
`define FPCD_DATA_U2 16'h0055
`define FPCD_DATA_PROG 16'h00A0
`define FPCD_DATA_SUB_A 16'h0025
`define FPCD_DATA_SUB_B 16'h0003
`define FPCD_DATA_CONF 16'h0029
`define FPCD_DATA_CFI 16'h0098
`define FPCD_DATA_EXIT 16'h00F0
`define FPCD_DATA_MEXIT 16'h0090
`define FPCD_DATA_NULL 16'h0000
`define FPCD_DATA_IRR 16'h0087
`define FPCD_PSR_RSVD 16'hFFE8
`define FPCD_WC_MAX 4'hF
`define FPCD_BASE_LSB 4
`define FPCD_LOW_MSB 10

// operation codes written to the control register
`define FPCD_OP_PW_PROG 5'h00
`define FPCD_OP_PW_READ 5'h01
`define FPCD_OP_PW_SUBMIT 5'h02
`define FPCD_OP_PSR_PROG 5'h03
`define FPCD_OP_READ 5'h04
`define FPCD_OP_GLB_READ 5'h05
`define FPCD_OP_CFI1 5'h06
`define FPCD_OP_CFI3 5'h07
`define FPCD_OP_EXIT1 5'h08
`define FPCD_OP_EXIT3 5'h09
`define FPCD_OP_ENTRY3 5'h0A
`define FPCD_OP_MEXIT 5'h0B
`define FPCD_OP_IRR_LOCK 5'h0C
`define FPCD_OP_BUF_START 5'h0D
`define FPCD_OP_BUF_WORD 5'h0E
`define FPCD_OP_BUF_CONF 5'h0F
`define FPCD_OP_RAW 5'h10

// register offsets
`define FPCD_REG_CTRL 12'h000
`define FPCD_REG_STATUS 12'h004
`define FPCD_REG_ADDR 12'h008
`define FPCD_REG_WDATA 12'h00C
`define FPCD_REG_SECLO 12'h010
`define FPCD_REG_SECHI 12'h014
`define FPCD_REG_RDATA 12'h018

// bus cycle strobe time
`define FPCD_STROBE_NS 40
`define FPCD_CLK_NS 8

`endif

// ---- verilog/fpcd_pkg.sv ----
/*
  Types shared by the controller and its bus cycle engine.
  Assumes the constants header is compiled alongside.
*/
`include "fpcd_defs.svh"
package fpcd_pkg;
  typedef struct packed {
    logic last;
    logic rd;
    logic cmdcyc;
    logic [21:0] addr;
    logic [15:0] data;
  } fpcd_cyc_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fpcd_seq_t;
  typedef enum logic [1:0] {EN_IDLE, EN_SETUP, EN_STROBE, EN_HOLD} fpcd_eng_t;
endpackage

// ---- verilog/fpcd_top.sv ----
/*
  Host-side controller that issues protection command sequences to a
  parallel flash, ordered by software over APB.
  Assumes an asynchronous x16 flash whose pins are sampled on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module fpcd_top
  import fpcd_pkg::*;
#(
  parameter int STROBE_CYC = (`FPCD_STROBE_NS + `FPCD_CLK_NS - 1) / `FPCD_CLK_NS
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  output logic [21:0] fl_addr,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  fpcd_cyc_if cyc ();

  fpcd_cycle #(.STROBE_CYC(STROBE_CYC)) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .cyc(cyc),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // cycle table

  function automatic fpcd_cyc_t cyc_of(input logic [4:0] op, input logic [2:0] idx,
    input logic [21:0] a, input logic [15:0] d, input logic [3:0] wc,
    input logic [63:0] sec, input logic [21:4] base);
    fpcd_cyc_t c;
    logic [21:0] unl_a;
    logic [15:0] unl_d;
    logic [1:0] part;
    c = '{last: 1'b1, rd: 1'b0, cmdcyc: 1'b1, addr: `FPCD_ADDR_ZERO, data: `FPCD_DATA_NULL};
    unl_a = (idx == 3'h0) ? `FPCD_ADDR_U1 : `FPCD_ADDR_U2;
    unl_d = (idx == 3'h0) ? `FPCD_DATA_U1 : `FPCD_DATA_U2;
    part = 2'(idx - 3'h2);
    case (op)
      `FPCD_OP_PW_PROG:
      begin
        c.last = (idx == 3'h1);
        // the portion value is data, not a command byte
        c.cmdcyc = (idx == 3'h0);
        c.data = (idx == 3'h0) ? `FPCD_DATA_PROG : d;
        c.addr = {20'h00000, a[1:0]};
      end
      `FPCD_OP_PW_READ:
      begin
        c.rd = 1'b1;
        c.addr = {20'h00000, a[1:0]};
      end
      `FPCD_OP_PW_SUBMIT:
      begin
        c.last = (idx == 3'h6);
        if (idx == 3'h0)
          c.data = `FPCD_DATA_SUB_A;
        else if (idx == 3'h1)
          c.data = `FPCD_DATA_SUB_B;
        else if (idx == 3'h6)
          c.data = `FPCD_DATA_CONF;
        else
        begin
          c.cmdcyc = 1'b0;
          c.addr = {20'h00000, part};
          c.data = sec[{part, 4'h0} +: 16];
        end
      end
      `FPCD_OP_PSR_PROG:
      begin
        c.last = (idx == 3'h1);
        c.cmdcyc = (idx == 3'h0);
        c.data = (idx == 3'h0) ? `FPCD_DATA_PROG : (d | `FPCD_PSR_RSVD);
      end
      `FPCD_OP_READ, `FPCD_OP_GLB_READ:
      begin
        c.rd = 1'b1;
        c.cmdcyc = 1'b0;
        c.addr = a;
      end
      `FPCD_OP_CFI1:
      begin
        c.addr = `FPCD_ADDR_CFI;
        c.data = `FPCD_DATA_CFI;
      end
      `FPCD_OP_EXIT1: c.data = `FPCD_DATA_EXIT;
      `FPCD_OP_CFI3, `FPCD_OP_EXIT3, `FPCD_OP_ENTRY3, `FPCD_OP_IRR_LOCK, `FPCD_OP_BUF_START:
      begin
        c.last = (op == `FPCD_OP_IRR_LOCK || op == `FPCD_OP_BUF_START) ?
          (idx == 3'h3) : (idx == 3'h2);
        if (idx < 3'h2)
        begin
          c.addr = unl_a;
          c.data = unl_d;
        end
        else if (op == `FPCD_OP_BUF_START)
        begin
          c.cmdcyc = 1'b0;
          c.addr = a;
          c.data = (idx == 3'h2) ? `FPCD_DATA_SUB_A : {12'h000, wc};
        end
        else if (idx == 3'h2)
        begin
          c.addr = `FPCD_ADDR_U1;
          case (op)
            `FPCD_OP_CFI3: c.data = `FPCD_DATA_CFI;
            `FPCD_OP_EXIT3: c.data = `FPCD_DATA_EXIT;
            `FPCD_OP_IRR_LOCK: c.data = `FPCD_DATA_IRR;
            default: c.data = {8'h00, d[7:0]};
          endcase
        end
      end
      `FPCD_OP_MEXIT:
      begin
        c.last = (idx == 3'h1);
        c.data = (idx == 3'h0) ? `FPCD_DATA_MEXIT : `FPCD_DATA_NULL;
      end
      `FPCD_OP_BUF_WORD, `FPCD_OP_RAW:
      begin
        c.cmdcyc = 1'b0;
        c.addr = a;
        c.data = d;
      end
      `FPCD_OP_BUF_CONF:
      begin
        c.cmdcyc = 1'b0;
        c.addr = {base, 4'h0};
        c.data = `FPCD_DATA_CONF;
      end
      default: c = c;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers and sequencer

  fpcd_seq_t st_reg, st_next;
  logic [4:0] op_reg, op_next;
  logic [2:0] idx_reg, idx_next;
  logic [21:0] addr_reg, addr_next;
  logic [15:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic [3:0] wc_reg, wc_next;
  logic [63:0] sec_reg, sec_next;
  logic done_reg, done_next, refused_reg, refused_next, glb_ok_reg, glb_ok_next;
  logic buf_open_reg, buf_open_next;
  logic [4:0] rem_reg, rem_next;
  logic [21:4] base_reg, base_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic wr_fire, rd_go, start, bad;
  fpcd_cyc_t cur;

  assign wr_fire = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && !pready;
  assign start = wr_fire && (paddr == `FPCD_REG_CTRL);
  assign cur = cyc_of(op_reg, idx_reg, addr_reg, wdat_reg, wc_reg, sec_reg, base_reg);

  always_comb
  begin
    bad = 1'b0;
    case (pwdata[4:0])
      `FPCD_OP_IRR_LOCK: bad = !glb_ok_reg;
      `FPCD_OP_BUF_WORD: bad = !buf_open_reg || (rem_reg == 5'h00) ||
        (addr_reg[21:`FPCD_BASE_LSB] != base_reg);
      `FPCD_OP_BUF_CONF: bad = !buf_open_reg || (rem_reg != 5'h00);
      default: bad = (pwdata[4:0] > `FPCD_OP_RAW);
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    idx_next = idx_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    wc_next = wc_reg;
    sec_next = sec_reg;
    rdat_next = rdat_reg;
    done_next = done_reg;
    refused_next = refused_reg;
    glb_ok_next = glb_ok_reg;
    buf_open_next = buf_open_reg;
    rem_next = rem_reg;
    base_next = base_reg;
    cyc.req = 1'b0;
    cyc.rd = cur.rd;
    cyc.addr = cur.addr;
    cyc.wdata = cur.data;
    if (wr_fire && st_reg == ST_IDLE)
    begin
      case (paddr)
        `FPCD_REG_ADDR: addr_next = pwdata[21:0];
        `FPCD_REG_WDATA:
        begin
          wdat_next = pwdata[15:0];
          wc_next = pwdata[19:16];
        end
        `FPCD_REG_SECLO: sec_next[31:0] = pwdata;
        `FPCD_REG_SECHI: sec_next[63:32] = pwdata;
        default: sec_next = sec_next;
      endcase
    end
    case (st_reg)
      ST_IDLE:
      begin
        if (start)
        begin
          done_next = 1'b0;
          refused_next = bad;
          if (!bad)
          begin
            op_next = pwdata[4:0];
            idx_next = 3'h0;
            st_next = ST_ISSUE;
          end
        end
      end
      ST_ISSUE:
      begin
        cyc.req = 1'b1;
        st_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cyc.done)
        begin
          if (cur.rd)
            rdat_next = cyc.rdata;
          if (!cur.last)
          begin
            idx_next = idx_reg + 3'h1;
            st_next = ST_ISSUE;
          end
          else
          begin
            done_next = 1'b1;
            st_next = ST_IDLE;
            case (op_reg)
              `FPCD_OP_GLB_READ: glb_ok_next = cyc.rdata[0];
              `FPCD_OP_BUF_START:
              begin
                buf_open_next = 1'b1;
                base_next = addr_reg[21:`FPCD_BASE_LSB];
                rem_next = {1'b0, wc_reg} + 5'h01;
              end
              `FPCD_OP_BUF_WORD: rem_next = rem_reg - 5'h01;
              `FPCD_OP_BUF_CONF: buf_open_next = 1'b0;
              default: rem_next = rem_reg;
            endcase
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // answer in the second access cycle so that read data leaves a flop
  always_comb
  begin
    pready_next = rd_go;
    pslverr_next = 1'b0;
    prdata_next = 32'h00000000;
    if (rd_go)
    begin
      case (paddr)
        `FPCD_REG_CTRL: prdata_next = {27'h0000000, op_reg};
        `FPCD_REG_STATUS: prdata_next = {18'h00000, rem_reg, 4'h0,
          buf_open_reg, glb_ok_reg, refused_reg, done_reg, (st_reg != ST_IDLE)};
        `FPCD_REG_ADDR: prdata_next = {10'h000, addr_reg};
        `FPCD_REG_WDATA: prdata_next = {12'h000, wc_reg, wdat_reg};
        `FPCD_REG_SECLO: prdata_next = sec_reg[31:0];
        `FPCD_REG_SECHI: prdata_next = sec_reg[63:32];
        `FPCD_REG_RDATA: prdata_next = {16'h0000, rdat_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= ST_IDLE;
      op_reg <= `FPCD_OP_PW_PROG;
      idx_reg <= 3'h0;
      addr_reg <= 22'h000000;
      wdat_reg <= 16'h0000;
      wc_reg <= 4'h0;
      sec_reg <= 64'h0000000000000000;
      rdat_reg <= 16'h0000;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      glb_ok_reg <= 1'b0;
      buf_open_reg <= 1'b0;
      rem_reg <= 5'h00;
      base_reg <= 18'h00000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      idx_reg <= idx_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      wc_reg <= wc_next;
      sec_reg <= sec_next;
      rdat_reg <= rdat_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
      glb_ok_reg <= glb_ok_next;
      buf_open_reg <= buf_open_next;
      rem_reg <= rem_next;
      base_reg <= base_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  chk_psr_reserved_high: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc.req && op_reg == `FPCD_OP_PSR_PROG && idx_reg == 3'h1) |->
    ((cyc.wdata & `FPCD_PSR_RSVD) == `FPCD_PSR_RSVD)) else $error("reserved bits low");
  chk_lock_needs_glb: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc.req && op_reg == `FPCD_OP_IRR_LOCK) |-> glb_ok_reg) else $error("lock without glb");
  chk_buf_same_base: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc.req && op_reg == `FPCD_OP_BUF_WORD) |->
    (cyc.addr[21:4] == base_reg)) else $error("buffer word off base");
  chk_buf_count_max: assert property (@(posedge pclk) disable iff (!presetn)
    rem_reg <= ({1'b0, `FPCD_WC_MAX} + 5'h01)) else $error("buffer count too big");
  chk_cmd_low_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc.req && cur.cmdcyc) |-> (cyc.addr[21:11] == 11'h000 &&
    cyc.wdata[15:8] == 8'h00)) else $error("command cycle upper bits set");
  chk_submit_tail: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc.req && op_reg == `FPCD_OP_PW_SUBMIT && cur.last) |->
    (idx_reg == 3'h6 && cyc.wdata == `FPCD_DATA_CONF)) else $error("bad submit end");
  chk_pw_prog_head: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc.req && op_reg == `FPCD_OP_PW_PROG && idx_reg == 3'h0) |->
    (cyc.wdata == `FPCD_DATA_PROG && !cur.last)) else $error("bad secret program head");
  chk_apb_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready longer than one cycle");
  chk_refuse_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (start && st_reg == ST_IDLE && bad) |=> (st_reg == ST_IDLE && refused_reg))
    else $error("refused op started");
endmodule // fpcd_top
`default_nettype wire
